/* hw/tcoc_top.v */
// Capture/compare control and timer output flip-flop for two timer instances
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "tcoc_consts.vh"

// Operation
// - Channel two value acts as compare when its mode bit is 0, capture when 1.
// - Channel one captures on pin b edge, or opposite edge of pin a.
// - Channel one value acts as compare at 0, capture at 1.
// - Opposite-phase capture with both-edge code on pin a never captures.
// - Writing 1 to soft trigger together with one-shot enable 1 fires one pulse; bit reads 0.
// - One-shot enable 0 gives successive pulses, 1 gives one-shot mode.
// - One-shot pulses in free-running and edge-clear modes; stop gives only the start strobe; never in clear-on-match.
// - Channel two match toggles output flip-flop when its enable is 1.
// - Channel one match toggles output flip-flop when its enable is 1.
// - Force pair: 00 keep, 01 clear, 10 set; 11 never written.
// - Force set and force clear bits read as 0.
// - Output enable 0 holds pin low, 1 passes flip-flop to pin.
// - Reset clears both control registers of each instance to zero.
// - Edge code 00 falling, 01 rising, 11 both, 10 prohibited.
module tcoc_top (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Register port
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Counter side, bit/slice 0 is instance a, 1 is instance b
  input wire [1:0] i_count_en,
  input wire [31:0] i_up_counter,
  input wire [5:0] i_counter_mode,
  input wire [7:0] i_edge_code,
  input wire [31:0] i_chan1_cmp_value,
  input wire [31:0] i_chan2_cmp_value,
  // Capture pins
  input wire [1:0] i_capture_in_a,
  input wire [1:0] i_capture_in_b,
  // Capture results
  output wire [31:0] o_chan1_value_reg,
  output wire [31:0] o_chan2_value_reg,
  output wire [1:0] o_chan1_capture,
  output wire [1:0] o_chan2_capture,
  // Timer output side
  output wire [1:0] o_oneshot_start,
  output wire [1:0] o_output_flipflop,
  output wire [1:0] o_timer_out_pin
);

  wire [15:0] cc_rd;
  wire [15:0] oc_rd;
  reg [7:0] rd_mux;

  // Equality of the counter with a channel value on a count clock pulse
  function match_at;
    input en;
    input [15:0] cnt;
    input [15:0] value;
    begin
      match_at = en & (cnt == value);
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
      wire [15:0] cc_addr;
      wire [15:0] oc_addr;
      wire wr_cc;
      wire wr_oc;
      wire [15:0] cnt;
      wire [1:0] mode;
      wire running;
      wire edge_a;
      wire edge_a_rev;
      wire edge_b;
      wire trig1;
      wire m1;
      wire m2;
      wire soft_trig;
      wire toggle;
      reg [2:0] cc_q;
      reg chan1_tog_q;
      reg chan2_tog_q;
      reg osm_q;
      reg toe_q;
      reg ff_q;
      reg ff_d;
      reg armed_q;
      reg start_q;
      reg pin_q;
      reg [15:0] cap1_q;
      reg [15:0] cap2_q;
      reg stb1_q;
      reg stb2_q;

      assign cc_addr = (gi == 0) ? `TCOC_CC_A_ADDR : `TCOC_CC_B_ADDR;
      assign oc_addr = (gi == 0) ? `TCOC_OC_A_ADDR : `TCOC_OC_B_ADDR;
      assign wr_cc = i_wr & (i_addr == cc_addr);
      assign wr_oc = i_wr & (i_addr == oc_addr);
      assign cnt = i_up_counter[gi*16 +: 16];
      assign mode = i_counter_mode[gi*3+1 +: 2];
      assign running = (mode != `TCOC_MODE_STOP);

      //////////////////////////////////////////////////////////////////////
      // Edge detectors for both capture pins of this instance
      tcoc_edge u_edge_a (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_sample(i_count_en[gi]),
        .i_pin(i_capture_in_a[gi]),
        .i_code(i_edge_code[gi*4 +: 2]),
        .o_edge(edge_a),
        .o_edge_rev(edge_a_rev)
      );

      tcoc_edge u_edge_b (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_sample(i_count_en[gi]),
        .i_pin(i_capture_in_b[gi]),
        .i_code(i_edge_code[gi*4+2 +: 2]),
        .o_edge(edge_b),
        .o_edge_rev()
      );

      //////////////////////////////////////////////////////////////////////
      // Capture trigger and compare matches; a channel in capture mode
      // never matches, so stale compare values cannot toggle the output
      assign trig1 = cc_q[`TCOC_CC_CHAN1_TRIGGER_SELECT] ? edge_a_rev : edge_b;
      assign m1 = ~cc_q[`TCOC_CC_CHAN1_CAPTURE_MODE] & running &
                  match_at(i_count_en[gi], cnt, i_chan1_cmp_value[gi*16 +: 16]);
      assign m2 = ~cc_q[`TCOC_CC_CHAN2_CAPTURE_MODE] & running &
                  match_at(i_count_en[gi], cnt, i_chan2_cmp_value[gi*16 +: 16]);

      // Soft trigger is refused in clear-on-match mode: no overflow, no pulse
      assign soft_trig = wr_oc & i_wdata[`TCOC_OC_ONESHOT_SOFT_TRIGGER] &
                         i_wdata[`TCOC_OC_ONESHOT_MODE_ENABLE] &
                         (mode != `TCOC_MODE_MATCH_CLEAR);

      // Toggle requests; in one-shot mode only an armed pulse may toggle
      assign toggle = ((chan1_tog_q & m1) ^ (chan2_tog_q & m2)) &
                      (~osm_q | armed_q);

      //////////////////////////////////////////////////////////////////////
      // Next flip-flop value; a force write beats a toggle in the same cycle
      always @* begin
        ff_d = ff_q ^ toggle;
        if (wr_oc) begin
          case ({i_wdata[`TCOC_OC_OUTFF_FORCE_SET], i_wdata[`TCOC_OC_OUTFF_FORCE_CLEAR]})
            2'h1: begin
              ff_d = 1'b0;
            end
            2'h2: begin
              ff_d = 1'b1;
            end
            default: begin
              ff_d = ff_q ^ toggle; // 11 is never written; treated as no change
            end
          endcase
        end
      end

      //////////////////////////////////////////////////////////////////////
      // Control registers; force and trigger bits are actions, never stored
      always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cc_q <= 3'h0;
          chan1_tog_q <= 1'b0;
          chan2_tog_q <= 1'b0;
          osm_q <= 1'b0;
          toe_q <= 1'b0;
        end else begin
          if (wr_cc) begin
            cc_q <= i_wdata[2:0];
          end
          if (wr_oc) begin
            chan1_tog_q <= i_wdata[`TCOC_OC_CHAN1_MATCH_TOGGLE_EN];
            chan2_tog_q <= i_wdata[`TCOC_OC_CHAN2_MATCH_TOGGLE_EN];
            osm_q <= i_wdata[`TCOC_OC_ONESHOT_MODE_ENABLE];
            toe_q <= i_wdata[`TCOC_OC_TIMER_OUT_ENABLE];
          end
        end
      end

      //////////////////////////////////////////////////////////////////////
      // Output flip-flop, one-shot arming and registered pin
      always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          ff_q <= 1'b0;
          armed_q <= 1'b0;
          start_q <= 1'b0;
          pin_q <= 1'b0;
        end else begin
          ff_q <= ff_d;
          start_q <= soft_trig; // Counter clears and starts on this pulse
          if (soft_trig) begin
            armed_q <= 1'b1;
          end else if (m1 | ~osm_q) begin
            armed_q <= 1'b0; // Channel one match ends the single pulse
          end
          // Pin is registered beside the flip-flop and held low when disabled
          pin_q <= (wr_oc ? i_wdata[`TCOC_OC_TIMER_OUT_ENABLE] : toe_q) & ff_d;
        end
      end

      //////////////////////////////////////////////////////////////////////
      // Capture registers with a one-cycle strobe per capture
      always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cap1_q <= 16'h0000;
          cap2_q <= 16'h0000;
          stb1_q <= 1'b0;
          stb2_q <= 1'b0;
        end else begin
          stb1_q <= cc_q[`TCOC_CC_CHAN1_CAPTURE_MODE] & trig1;
          stb2_q <= cc_q[`TCOC_CC_CHAN2_CAPTURE_MODE] & edge_a;
          if (cc_q[`TCOC_CC_CHAN1_CAPTURE_MODE] & trig1) begin
            cap1_q <= cnt;
          end
          if (cc_q[`TCOC_CC_CHAN2_CAPTURE_MODE] & edge_a) begin
            cap2_q <= cnt;
          end
        end
      end

      // Readback: trigger and force bits always read 0
      assign cc_rd[gi*8 +: 8] = {5'h00, cc_q};
      assign oc_rd[gi*8 +: 8] = {2'h0, osm_q, chan2_tog_q, 2'h0,
                                 chan1_tog_q, toe_q};

      assign o_chan1_value_reg[gi*16 +: 16] = cap1_q;
      assign o_chan2_value_reg[gi*16 +: 16] = cap2_q;
      assign o_chan1_capture[gi] = stb1_q;
      assign o_chan2_capture[gi] = stb2_q;
      assign o_oneshot_start[gi] = start_q;
      assign o_output_flipflop[gi] = ff_q;
      assign o_timer_out_pin[gi] = pin_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped addresses read as zero
  always @* begin
    case (i_addr)
      `TCOC_CC_A_ADDR: begin
        rd_mux = cc_rd[7:0];
      end
      `TCOC_OC_A_ADDR: begin
        rd_mux = oc_rd[7:0];
      end
      `TCOC_CC_B_ADDR: begin
        rd_mux = cc_rd[15:8];
      end
      `TCOC_OC_B_ADDR: begin
        rd_mux = oc_rd[15:8];
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end

endmodule // tcoc_top

/* common/tcoc_consts.vh */
// Constants for the timer capture/compare and output control block
`ifndef TCOC_CONSTS_VH
`define TCOC_CONSTS_VH

// Register byte addresses, instance a then instance b
`define TCOC_CC_A_ADDR 16'hffbc
`define TCOC_OC_A_ADDR 16'hffbd
`define TCOC_CC_B_ADDR 16'hffb8
`define TCOC_OC_B_ADDR 16'hffb9

// Reset values
`define TCOC_CC_RESET 8'h00
`define TCOC_OC_RESET 8'h00

// Capture/compare control fields
`define TCOC_CC_CHAN1_CAPTURE_MODE 0
`define TCOC_CC_CHAN1_TRIGGER_SELECT 1
`define TCOC_CC_CHAN2_CAPTURE_MODE 2

// Output control fields
`define TCOC_OC_TIMER_OUT_ENABLE 0
`define TCOC_OC_CHAN1_MATCH_TOGGLE_EN 1
`define TCOC_OC_OUTFF_FORCE_CLEAR 2
`define TCOC_OC_OUTFF_FORCE_SET 3
`define TCOC_OC_CHAN2_MATCH_TOGGLE_EN 4
`define TCOC_OC_ONESHOT_MODE_ENABLE 5
`define TCOC_OC_ONESHOT_SOFT_TRIGGER 6

// Edge codes; 2'h2 is the prohibited code
`define TCOC_EDGE_FALL 2'h0
`define TCOC_EDGE_RISE 2'h1
`define TCOC_EDGE_BAD 2'h2
`define TCOC_EDGE_BOTH 2'h3

// Counter mode codes, upper two bits of the three-bit mode
`define TCOC_MODE_STOP 2'h0
`define TCOC_MODE_FREE 2'h1
`define TCOC_MODE_EDGE_CLEAR 2'h2
`define TCOC_MODE_MATCH_CLEAR 2'h3

`endif

/* hw/tcoc_edge.v */
// Valid edge detector for one capture input pin
`timescale 1ns/1ps
`include "tcoc_consts.vh"

module tcoc_edge (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Sampling and pin
  input wire i_sample,
  input wire i_pin,
  input wire [1:0] i_code,
  // Edge pulses
  output reg o_edge,
  output reg o_edge_rev
);

  reg last_q;
  wire rise;
  wire fall;

  ////////////////////////////////////////////////////////////////////////////
  // Pin history, taken only on the count clock so short glitches are missed
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      last_q <= 1'b0; // A pin high after reset shows as a rising edge
    end else if (i_sample) begin
      last_q <= i_pin;
    end
  end

  assign rise = i_sample & i_pin & ~last_q;
  assign fall = i_sample & ~i_pin & last_q;

  ////////////////////////////////////////////////////////////////////////////
  // Valid edge and its opposite phase; both-edge code has no opposite
  always @* begin
    o_edge = 1'b0;
    o_edge_rev = 1'b0;
    case (i_code)
      `TCOC_EDGE_FALL: begin
        o_edge = fall;
        o_edge_rev = rise;
      end
      `TCOC_EDGE_RISE: begin
        o_edge = rise;
        o_edge_rev = fall;
      end
      `TCOC_EDGE_BOTH: begin
        o_edge = rise | fall;
        o_edge_rev = 1'b0;
      end
      default: begin // Prohibited code detects nothing
        o_edge = 1'b0;
        o_edge_rev = 1'b0;
      end
    endcase
  end

endmodule // tcoc_edge

/* verification/tcoc_properties.sv */
// Checker for the register port and output flip-flop of instance a
`timescale 1ns/1ps
module tcoc_props (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Register port
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  // Counter side
  input wire [1:0] i_count_en,
  input wire [31:0] i_up_counter,
  // Results
  input wire [31:0] o_chan1_value_reg,
  input wire [31:0] o_chan2_value_reg,
  input wire [1:0] o_chan1_capture,
  input wire [1:0] o_chan2_capture,
  input wire [1:0] o_oneshot_start,
  input wire [1:0] o_output_flipflop,
  input wire [1:0] o_timer_out_pin
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Output enable as last written, so the pin level can be judged from the rule
  reg toe_seen_q;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      toe_seen_q <= 1'b0;
    end else if (i_wr && i_addr == 16'hffbd) begin
      toe_seen_q <= i_wdata[0];
    end
  end
  ////////////////////////////////////////////////////////////
  // Read-back hides reserved and self-clearing bits
  property p_oc_read;
    $past(i_rd) && $past(i_addr) == 16'hffbd |-> o_rdata[7:6] == 2'h0 && o_rdata[3:2] == 2'h0;
  endproperty
  a_oc_read: assert property (p_oc_read) else $error("output control read shows write-only bits");
  property p_cc_read; $past(i_rd) && $past(i_addr) == 16'hffbc |-> o_rdata[7:3] == 5'h00; endproperty
  a_cc_read: assert property (p_cc_read) else $error("mode control read shows upper bits");
  // Forced levels land one cycle after the write, whatever the match does
  property p_fset; i_wr && i_addr == 16'hffbd && i_wdata[3:2] == 2'h2 |=> o_output_flipflop[0]; endproperty
  a_fset: assert property (p_fset) else $error("forced set missed");
  property p_fclr; i_wr && i_addr == 16'hffbd && i_wdata[3:2] == 2'h1 |=> !o_output_flipflop[0]; endproperty
  a_fclr: assert property (p_fclr) else $error("forced clear missed");
  // Pin shows the flip-flop while enabled and stays low while disabled
  property p_pin; o_timer_out_pin[0] == (toe_seen_q && o_output_flipflop[0]); endproperty
  a_pin: assert property (p_pin) else $error("pin differs from enable and flip-flop");
  property p_os; o_oneshot_start[0] |-> $past(i_wr && i_addr == 16'hffbd && i_wdata[6]); endproperty
  a_os: assert property (p_os) else $error("one-shot start without trigger write");
  // Captured value is the counter seen at the sampling enable
  property p_cap2;
    o_chan2_capture[0] |-> o_chan2_value_reg[15:0] == $past(i_up_counter[15:0]);
  endproperty
  a_cap2: assert property (p_cap2) else $error("channel two capture value wrong");
  property p_cap1;
    o_chan1_capture[0] |-> o_chan1_value_reg[15:0] == $past(i_up_counter[15:0]);
  endproperty
  a_cap1: assert property (p_cap1) else $error("channel one capture value wrong");
  // Without an enable or a write the flip-flop must not move
  property p_hold;
    !$past(i_count_en[0]) && !$past(i_count_en[0], 2) && !$past(i_wr) |-> $stable(o_output_flipflop[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("flip-flop moved with no cause");
  c_set: cover property (i_wr && i_addr == 16'hffbd && i_wdata[3:2] == 2'h2);
  c_cap: cover property (o_chan1_capture[0]);
  c_os: cover property (o_oneshot_start[0]);
endmodule // tcoc_props
bind tcoc_top tcoc_props u_props (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_count_en, .i_up_counter, .o_chan1_value_reg, .o_chan2_value_reg, .o_chan1_capture,
  .o_chan2_capture, .o_oneshot_start, .o_output_flipflop, .o_timer_out_pin);

/* verification/tcoc_pin_model.sv */
// Behavioural source for the capture input pins
`timescale 1ns/1ps
module tcoc_pin_model (
  // Clock
  input wire i_clk,
  // Pins, bit 0 is instance a
  output logic [1:0] o_pin_a,
  output logic [1:0] o_pin_b
);
  // Idle low, so the reset edge history sees no false edge
  initial begin
    o_pin_a = 2'h0;
    o_pin_b = 2'h0;
  end
  // Move one pin after an edge, then hold it past two count periods
  task automatic move(input bit sel_b, input logic lvl);
    @(posedge i_clk);
    if (sel_b)
      o_pin_b[0] <= lvl;
    else
      o_pin_a[0] <= lvl;
    repeat (3) @(posedge i_clk);
  endtask
endmodule // tcoc_pin_model

/* verification/timer_capture_output_control_tb.sv */
// Self-checking bench for the capture/compare and output control block
`timescale 1ns/1ps
module timer_capture_output_control_tb;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] q;} tcoc_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [1:0] cnt_en = 2'h0;
  logic [31:0] cnt = 32'h0;
  logic [5:0] mode = 6'h00;
  logic [7:0] ecode = 8'h00;
  logic exp_ff;
  wire [7:0] rdata;
  wire [31:0] v1;
  wire [31:0] v2;
  wire [1:0] cap1;
  wire [1:0] cap2;
  wire [1:0] os;
  wire [1:0] ff;
  wire [1:0] tpin;
  wire [1:0] pa;
  wire [1:0] pb;
  int n_fail = 0;
  int n_compared = 0;
  int n_c1 = 0;
  int n_c2 = 0;
  int n_os = 0;
  int cyc = 0;
  logic [15:0] regs [4] = '{16'hffb8, 16'hffb9, 16'hffbc, 16'hffbd};
  logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
  // Unmapped address last: writes are dropped, reads give zero
  tcoc_row_t rows [5] = '{'{16'hffbc, 8'hff, 8'h07}, '{16'hffb8, 8'h06, 8'h06},
    '{16'hffbd, 8'hb3, 8'h33}, '{16'hffb9, 8'h91, 8'h11}, '{16'hffba, 8'hff, 8'h00}};
  ////////////////////////////////////////////////////////////
  tcoc_pin_model pins (.i_clk(clk), .o_pin_a(pa), .o_pin_b(pb));
  tcoc_top uut (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .i_count_en(cnt_en), .i_up_counter(cnt),
    .i_counter_mode(mode), .i_edge_code(ecode), .i_chan1_cmp_value(32'h0000_1234),
    .i_chan2_cmp_value(32'h0000_5678), .i_capture_in_a(pa), .i_capture_in_b(pb),
    .o_chan1_value_reg(v1), .o_chan2_value_reg(v2), .o_chan1_capture(cap1),
    .o_chan2_capture(cap2), .o_oneshot_start(os), .o_output_flipflop(ff),
    .o_timer_out_pin(tpin));
  // Clock, event counters and the hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    n_c1 += cap1[0];
    n_c2 += cap2[0];
    n_os += os[0];
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_v({15'h0, got}, {15'h0, exp});
  endtask
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [15:0] a, input logic [7:0] q);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk_v({8'h0, rdata}, {8'h0, q});
  endtask
  // One count enable pulse with the counter value beside it
  task automatic tick(input logic [15:0] c);
    @(posedge clk);
    cnt[15:0] <= c;
    cnt_en <= 2'h1;
    @(posedge clk);
    cnt_en <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Counter is stopped around every control write; mode moves only on an edge
  task automatic cfg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    mode <= 6'h00;
    reg_wr(a, d);
    @(posedge clk);
    mode <= 6'h12;
    #1;
  endtask
  task automatic pulse(input bit b, input logic [15:0] c);
    n_c1 = 0;
    n_c2 = 0;
    @(posedge clk);
    cnt[15:0] <= c;
    cnt_en <= 2'h3;
    pins.move(b, 1'b1);
    pins.move(b, 1'b0);
    cnt_en <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (regs[i]) reg_rd(regs[i], 8'h00);
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].d);
      reg_rd(rows[i].a, rows[i].q);
    end
    reg_wr(16'hffbc, 8'h00);
    reg_wr(16'hffbd, 8'h01);
    reg_wr(16'hffbd, 8'h09);
    chk_b(ff[0], 1'b1);
    @(posedge clk);
    #1 chk_b(tpin[0], 1'b1);
    // Pair 00 leaves the flip-flop alone; pair 11 is never written
    reg_wr(16'hffbd, 8'h01);
    chk_b(ff[0], 1'b1);
    reg_wr(16'hffbd, 8'h05);
    chk_b(ff[0], 1'b0);
    reg_wr(16'hffbd, 8'h09);
    reg_wr(16'hffbd, 8'h00);
    @(posedge clk);
    #1 chk_b(tpin[0], 1'b0);
    // Instance b flip-flop and pin, enable first, force in a later write
    reg_wr(16'hffb9, 8'h01);
    reg_wr(16'hffb9, 8'h09);
    chk_b(ff[1], 1'b1);
    chk_b(tpin[1], 1'b1);
    // Each channel's match, toggle enabled and disabled
    for (int k = 0; k < 4; k++) begin
      cfg(16'hffbd, k[1] ? {3'h0, k[0], 4'h1} : {6'h0, k[0], 1'b1});
      exp_ff = ff[0] ^ k[0];
      tick(k[1] ? 16'h5678 : 16'h1234);
      chk_b(ff[0], exp_ff);
    end
    // Force set against a channel two toggle that would drop the flip-flop
    cfg(16'hffbd, 8'h19);
    @(posedge clk);
    wr_s <= 1'b1;
    wdata <= 8'h19;
    cnt_en <= 2'h1;
    @(posedge clk);
    wr_s <= 1'b0;
    cnt_en <= 2'h0;
    repeat (2) @(posedge clk);
    #1 chk_b(ff[0], 1'b1);
    // Pin a edges for every valid code, direct and reverse phase
    foreach (codes[i]) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge clk);
        ecode <= {6'h01, codes[i]};
        cfg(16'hffbc, s ? 8'h07 : 8'h05);
        pulse(1'b0, 16'habcd);
        chk_v(n_c2[15:0], codes[i] == 2'h3 ? 16'h2 : 16'h1);
        chk_v(n_c1[15:0], (s == 0 || codes[i] == 2'h3) ? 16'h0 : 16'h1);
      end
    end
    chk_v(v2[15:0], 16'habcd);
    cfg(16'hffbc, 8'h05);
    pulse(1'b1, 16'h0f0f);
    chk_v(n_c1[15:0], 16'h1);
    chk_v(v1[15:0], 16'h0f0f);
    cfg(16'hffbc, 8'h00);
    pulse(1'b0, 16'h0f0f);
    chk_v(n_c2[15:0], 16'h0);
    // One-shot trigger, then refused under clear-on-match
    cfg(16'hffbd, 8'h21);
    n_os = 0;
    reg_wr(16'hffbd, 8'h61);
    reg_rd(16'hffbd, 8'h21);
    repeat (3) tick(16'h0f0f);
    chk_v(n_os[15:0], 16'h1);
    // Soft trigger write under clear-on-match gives no further start pulse
    @(posedge clk);
    mode <= 6'h16;
    reg_wr(16'hffbd, 8'h61);
    repeat (3) tick(16'h0f0f);
    chk_v(n_os[15:0], 16'h1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(16'hffbd, 8'h00);
    reg_rd(16'hffbc, 8'h00);
    chk_b(ff[0], 1'b0);
    final_report();
  end
endmodule // timer_capture_output_control_tb
